// ===== hdl/ssl_defs.vh
// constants for the serial slave link: timing, codes, frame layout
// assumes a 200 MHz system clock
`ifndef SSL_DEFS_VH
`define SSL_DEFS_VH
`define SSL_CLK_HZ 200000000
`define SSL_COMM_MODBUS 2'h0
`define SSL_BAUD_DEFAULT 3'h5
`define SSL_FMT_8N2 2'h0
`define SSL_FMT_8E1 2'h1
`define SSL_FMT_8O1 2'h2
`define SSL_FMT_8N1 2'h3
`define SSL_ADDR_DEFAULT 8'h01
`define SSL_ADDR_BCAST 8'h00
`define SSL_ADDR_MAX 8'hf9
`define SSL_DELAY_MS_MAX 5'h14
`define SSL_DELAY_MS_DEFAULT 5'h02
`define SSL_CYC_PER_MS 200000
`define SSL_CYC_PER_100MS 20000000
`define SSL_TMO_MAX 10'h258
`define SSL_SILENT_CHARS_X2 28'h7
`define SSL_CHAR_BITS_MAX 28'hb
`define SSL_FN_READ 8'h03
`define SSL_MAXLEN 16
`endif

// ===== hdl/ssl_link.v
// serial slave link of a motor drive: rtu-style framing, address match,
// response delay, inactivity fault, read reply framing and current scaling
// assumes rx pin async to clk_sys; request execution done by drive logic
`timescale 1ns/10ps
`include "ssl_defs.vh"
module ssl_link #(
  parameter CLK_HZ = `SSL_CLK_HZ,
  parameter CYC_PER_MS = `SSL_CYC_PER_MS,
  parameter CYC_PER_100MS = `SSL_CYC_PER_100MS
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // configuration
  input wire [1:0] comm_type,
  input wire [2:0] baud_code,
  input wire [1:0] fmt_code,
  input wire [7:0] station_addr,
  input wire [4:0] resp_delay_ms,
  input wire [9:0] timeout_100ms,
  input wire proto_std,
  input wire cur_res_coarse,
  // serial pins
  input wire rx_pin,
  output wire tx_pin,
  output wire tx_oe,
  // request to drive logic
  output reg req_valid_q,
  output reg req_bcast_q,
  output reg [7:0] req_func_q,
  output reg [15:0] req_reg_q,
  output reg [15:0] req_val_q,
  // answer from drive logic
  input wire ans_valid,
  input wire [15:0] ans_data,
  input wire [15:0] cur_raw_10ma,
  // status
  output reg link_timeout_fault_q,
  input wire fault_clear
);
  // bit period from code; every rate fits 20 bits at the nominal clock
  reg [31:0] bit_full;
  always @* begin
    case (baud_code)
      3'h0: bit_full = CLK_HZ / 300;
      3'h1: bit_full = CLK_HZ / 600;
      3'h2: bit_full = CLK_HZ / 1200;
      3'h3: bit_full = CLK_HZ / 2400;
      3'h4: bit_full = CLK_HZ / 4800;
      3'h5: bit_full = CLK_HZ / 9600;
      3'h6: bit_full = CLK_HZ / 19200;
      default: bit_full = CLK_HZ / 38400;
    endcase
  end
  wire [19:0] bit_cyc = bit_full[19:0];
  wire par_en = (fmt_code == `SSL_FMT_8E1) || (fmt_code == `SSL_FMT_8O1);
  wire par_odd = (fmt_code == `SSL_FMT_8O1);
  wire two_stop = (fmt_code == `SSL_FMT_8N2);
  wire link_on = (comm_type == `SSL_COMM_MODBUS);
  // rx synchroniser, three stages, change on agreement of last two
  reg s1_q, s2_q, s3_q, rx_q;
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      rx_q <= 1'b1;
    end else begin
      s1_q <= rx_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) rx_q <= s2_q;
    end
  end
  // receiver: start, 8 data lsb first, optional parity, stop
  reg [19:0] rcnt_q;
  reg [3:0] rbit_q;
  reg rbusy_q, rpar_err_q, rbyte_q;
  reg [7:0] rsh_q;
  reg [7:0] rbyte_data_q;
  wire [3:0] rlast = par_en ? 4'ha : 4'h9;
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      rcnt_q <= 20'h0;
      rbit_q <= 4'h0;
      rbusy_q <= 1'b0;
      rpar_err_q <= 1'b0;
      rsh_q <= 8'h0;
      rbyte_q <= 1'b0;
      rbyte_data_q <= 8'h0;
    end else begin
      rbyte_q <= 1'b0;
      if (!rbusy_q) begin
        if (!rx_q && link_on) begin
          rbusy_q <= 1'b1;
          rcnt_q <= {1'b0, bit_cyc[19:1]}; // sample mid-bit
          rbit_q <= 4'h0;
          rpar_err_q <= 1'b0;
        end
      end else if (rcnt_q != 20'h0) begin
        rcnt_q <= rcnt_q - 20'h1;
      end else begin
        rcnt_q <= bit_cyc - 20'h1;
        rbit_q <= rbit_q + 4'h1;
        if (rbit_q == 4'h0 && rx_q) rbusy_q <= 1'b0; // false start
        else if (rbit_q >= 4'h1 && rbit_q <= 4'h8) rsh_q <= {rx_q, rsh_q[7:1]};
        else if (rbit_q == 4'h9 && par_en)
          rpar_err_q <= (^rsh_q ^ rx_q) != par_odd;
        if (rbit_q == rlast) begin
          rbusy_q <= 1'b0;
          rbyte_q <= rx_q && !rpar_err_q;
          rbyte_data_q <= rsh_q;
        end
      end
    end
  end
  // crc-16 step over one byte
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] b;
    integer i;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, b};
      for (i = 0; i < 8; i = i + 1)
        t = t[0] ? ((t >> 1) ^ 16'ha001) : (t >> 1);
      crc_byte = t;
    end
  endfunction
  // frame assembly and silent-gap end detection
  reg [7:0] fbuf_q [0:`SSL_MAXLEN-1];
  reg [4:0] flen_q;
  reg [15:0] fcrc_q;
  reg [27:0] gap_q;
  reg fopen_q, fend_q;
  // 3.5 of the longest characters; 28 bits so the slowest rate does not wrap
  wire [27:0] gap_x2 = {8'h00, bit_cyc} * `SSL_CHAR_BITS_MAX * `SSL_SILENT_CHARS_X2;
  wire [27:0] gap_lim = {1'b0, gap_x2[27:1]};
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      flen_q <= 5'h0;
      fcrc_q <= 16'hffff;
      gap_q <= 28'h0;
      fopen_q <= 1'b0;
      fend_q <= 1'b0;
    end else begin
      fend_q <= 1'b0;
      if (rbyte_q) begin
        gap_q <= 28'h0;
        fopen_q <= 1'b1;
        if (flen_q < `SSL_MAXLEN) begin
          fbuf_q[flen_q[3:0]] <= rbyte_data_q;
          flen_q <= flen_q + 5'h1;
        end
        fcrc_q <= crc_byte(fcrc_q, rbyte_data_q);
      end else if (rbusy_q) begin
        gap_q <= 28'h0;
      end else if (fopen_q) begin
        if (gap_q >= gap_lim) begin // 3.5 characters of silence
          fopen_q <= 1'b0;
          fend_q <= 1'b1;
        end else gap_q <= gap_q + 28'h1;
      end else begin
        flen_q <= 5'h0;
        fcrc_q <= 16'hffff;
      end
    end
  end
  // a good frame leaves a zero residue over data plus crc
  wire faddr_bc = (fbuf_q[0] == `SSL_ADDR_BCAST);
  wire faddr_me = (fbuf_q[0] == station_addr) && (station_addr != `SSL_ADDR_BCAST)
    && (station_addr <= `SSL_ADDR_MAX);
  wire fgood = fend_q && (flen_q == 5'h8) && (fcrc_q == 16'h0000);
  // request and reply sequencing
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SEND = 2'h2;
  reg [1:0] st_q;
  reg [24:0] dly_q;
  reg have_ans_q;
  reg [15:0] ans_q;
  reg [7:0] obuf_q [0:7];
  reg [3:0] olen_q;
  wire tx_done;
  wire [31:0] dly_full = resp_delay_ms * CYC_PER_MS; // 31 ms at most from the 5-bit setting, fits 25 bits
  wire [15:0] cur_scaled = cur_res_coarse ? (cur_raw_10ma / 16'd10) : cur_raw_10ma;
  wire is_cur = (req_reg_q == 16'h0000);
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      dly_q <= 25'h0;
      have_ans_q <= 1'b0;
      ans_q <= 16'h0;
      req_valid_q <= 1'b0;
      req_bcast_q <= 1'b0;
      req_func_q <= 8'h0;
      req_reg_q <= 16'h0;
      req_val_q <= 16'h0;
      olen_q <= 4'h0;
    end else begin
      req_valid_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (fgood && (faddr_bc || faddr_me)) begin
            req_valid_q <= 1'b1;
            req_bcast_q <= faddr_bc;
            req_func_q <= fbuf_q[1];
            req_reg_q <= {fbuf_q[2], fbuf_q[3]};
            req_val_q <= {fbuf_q[4], fbuf_q[5]};
            have_ans_q <= 1'b0;
            // delay counted from frame end
            dly_q <= dly_full[24:0];
            st_q <= faddr_bc ? ST_IDLE : ST_WAIT; // no reply to broadcast
          end
        end
        ST_WAIT: begin
          if (dly_q != 25'h0) dly_q <= dly_q - 25'h1;
          if (ans_valid && !have_ans_q) begin
            have_ans_q <= 1'b1;
            ans_q <= (req_func_q == `SSL_FN_READ && is_cur) ? cur_scaled : ans_data;
          end
          if (have_ans_q && dly_q == 25'h0) begin // later of both
            obuf_q[0] <= station_addr;
            obuf_q[1] <= req_func_q;
            if (req_func_q == `SSL_FN_READ) begin
              obuf_q[2] <= 8'h02;
              obuf_q[3] <= ans_q[15:8];
              obuf_q[4] <= ans_q[7:0];
              obuf_q[5] <= 8'h00; // extra byte in non-standard mode
              olen_q <= proto_std ? 4'h5 : 4'h6;
            end else begin
              obuf_q[2] <= req_reg_q[15:8];
              obuf_q[3] <= req_reg_q[7:0];
              obuf_q[4] <= req_val_q[15:8];
              obuf_q[5] <= req_val_q[7:0];
              olen_q <= 4'h6;
            end
            st_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tx_done) st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  // transmitter: serialises obuf then crc low, crc high
  reg [19:0] tcnt_q;
  reg [3:0] tbit_q;
  reg [10:0] tsh_q;
  reg [3:0] tpos_q;
  reg [15:0] tcrc_q;
  reg tx_q, tdone_q, tact_q;
  wire [3:0] tlast = (par_en || two_stop) ? 4'ha : 4'h9;
  wire [7:0] tbyte = (tpos_q < olen_q) ? obuf_q[tpos_q[2:0]] :
    (tpos_q == olen_q) ? tcrc_q[7:0] : tcrc_q[15:8];
  wire tparity = ^tbyte ^ par_odd;
  assign tx_done = tdone_q;
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      tcnt_q <= 20'h0;
      tbit_q <= 4'h0;
      tsh_q <= 11'h7ff;
      tact_q <= 1'b0;
      tpos_q <= 4'h0;
      tcrc_q <= 16'hffff;
      tx_q <= 1'b1;
      tdone_q <= 1'b0;
    end else begin
      tdone_q <= 1'b0;
      if (st_q == ST_SEND && !tact_q && !tdone_q) begin
        if (tpos_q == olen_q + 4'h2) begin
          tdone_q <= 1'b1;
          tpos_q <= 4'h0;
          tcrc_q <= 16'hffff;
        end else begin
          tact_q <= 1'b1;
          tbit_q <= 4'h0;
          tcnt_q <= bit_cyc - 20'h1;
          tsh_q <= {1'b1, par_en ? tparity : 1'b1, tbyte, 1'b0};
          if (tpos_q < olen_q) tcrc_q <= crc_byte(tcrc_q, tbyte);
        end
      end else if (tact_q) begin
        tx_q <= tsh_q[0];
        if (tcnt_q != 20'h0) tcnt_q <= tcnt_q - 20'h1;
        else begin
          tcnt_q <= bit_cyc - 20'h1;
          tsh_q <= {1'b1, tsh_q[10:1]};
          tbit_q <= tbit_q + 4'h1;
          if (tbit_q == tlast) begin
            tact_q <= 1'b0;
            tpos_q <= tpos_q + 4'h1;
          end
        end
      end else tx_q <= 1'b1;
    end
  end
  assign tx_pin = tx_q;
  assign tx_oe = (st_q == ST_SEND);
  // inactivity supervision in 100 ms ticks
  reg [24:0] tick_q;
  reg [9:0] idle_q;
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      tick_q <= 25'h0;
      idle_q <= 10'h0;
      link_timeout_fault_q <= 1'b0;
    end else if (timeout_100ms == 10'h0 || fgood) begin
      tick_q <= 25'h0;
      idle_q <= 10'h0;
      if (fault_clear) link_timeout_fault_q <= 1'b0;
    end else begin
      if (tick_q == CYC_PER_100MS - 1) begin
        tick_q <= 25'h0;
        if (idle_q != 10'h3ff) idle_q <= idle_q + 10'h1;
      end else tick_q <= tick_q + 25'h1;
      if (idle_q > timeout_100ms) link_timeout_fault_q <= 1'b1;
      else if (fault_clear) link_timeout_fault_q <= 1'b0;
    end
  end
endmodule // ssl_link

// ===== sim/ssl_link_properties.sv
// concurrent checks on the serial slave link top-level ports
// assumes one clock clk_sys and a synchronous active-low reset_n
`timescale 1ns/10ps
module ssl_link_chk #(
  parameter CYC_PER_MS = 200000
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // settings
  input wire [1:0] comm_type,
  input wire [7:0] station_addr,
  input wire [4:0] resp_delay_ms,
  input wire [9:0] timeout_100ms,
  // observed activity
  input wire tx_pin,
  input wire tx_oe,
  input wire req_valid_q,
  input wire req_bcast_q,
  input wire ans_valid,
  input wire link_timeout_fault_q,
  input wire fault_clear
);
  logic [31:0] dly_q;
  logic ans_q;
  logic bc_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // age of the last taken request, and whether its answer has come
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      dly_q <= 32'h0;
      ans_q <= 1'b0;
      bc_q <= 1'b0;
    end else if (req_valid_q) begin
      dly_q <= 32'h1;
      ans_q <= ans_valid;
      bc_q <= req_bcast_q;
    end else begin
      dly_q <= dly_q + 32'h1;
      ans_q <= ans_q | ans_valid;
    end
  end
  tx_idle_a: assert property (!tx_oe |-> tx_pin)
    else $error("tx line low while released");
  req_pulse_a: assert property (req_valid_q |=> !req_valid_q)
    else $error("request strobe longer than one cycle");
  bcast_quiet_a: assert property (bc_q |-> !tx_oe)
    else $error("reply driven after a broadcast");
  own_addr_a: assert property (req_valid_q && station_addr == 8'h00 |-> req_bcast_q)
    else $error("station zero took a point-to-point frame");
  // a 2 cycle slack covers the frame-end to strobe step
  reply_late_a: assert property ($rose(tx_oe) |->
    ans_q && dly_q + 32'h2 >= resp_delay_ms * CYC_PER_MS)
    else $error("reply started too early");
  modbus_only_a: assert property (comm_type != 2'h0 |-> !req_valid_q)
    else $error("request taken with foreign link type");
  tmo_off_a: assert property (timeout_100ms == 10'h0 && !link_timeout_fault_q
    |=> !link_timeout_fault_q)
    else $error("fault raised with supervision off");
  fault_hold_a: assert property (link_timeout_fault_q && !fault_clear |=> link_timeout_fault_q)
    else $error("fault dropped without clear");
endmodule // ssl_link_chk

// ===== sim/ssl_host.sv
// host model: bus master sending read frames and collecting reply bytes
// assumes bit_cyc and fmt are set by the bench to match the device
`timescale 1ns/10ps
module ssl_host (
  // clock
  input wire clk_sys,
  // line
  output logic rx_pin,
  input wire tx_pin,
  input wire tx_oe,
  // character settings
  input wire [31:0] bit_cyc,
  input wire [1:0] fmt
);
  logic [7:0] rxq[$];
  logic [7:0] b;
  wire line = tx_oe ? tx_pin : 1'b1; // released line rests at the pull-up level
  initial rx_pin = 1'b1;
  // frame check value, reflected polynomial
  function automatic logic [15:0] crc16(input logic [7:0] m[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (m[i]) begin
      c = c ^ {8'h00, m[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic put(input logic v);
    rx_pin <= v;
    repeat (bit_cyc) @(posedge clk_sys);
  endtask
  // same rate and format as the device, or nothing gets through
  task automatic put_byte(input logic [7:0] d);
    put(1'b0);
    for (int i = 0; i < 8; i++) put(d[i]);
    if (fmt == 2'h1 || fmt == 2'h2) put(^d ^ (fmt == 2'h2));
    put(1'b1);
    if (fmt == 2'h0) put(1'b1);
  endtask
  // read request; bad flips one check bit
  task automatic send(input logic [7:0] a, input logic [15:0] r, input logic bad);
    logic [7:0] m[$];
    logic [15:0] c;
    m = '{a, 8'h03, r[15:8], r[7:0], 8'h00, 8'h01};
    c = crc16(m) ^ {15'h0, bad};
    m.push_back(c[7:0]);
    m.push_back(c[15:8]);
    foreach (m[i]) put_byte(m[i]);
  endtask
  // reply collector, samples data bits at their middle
  always begin
    @(posedge clk_sys);
    if (!line) begin
      repeat (bit_cyc / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge clk_sys);
        b[i] = line;
      end
      rxq.push_back(b);
      repeat (bit_cyc * ((fmt == 2'h1 || fmt == 2'h2) ? 2 : 1)) @(posedge clk_sys);
    end
  end
endmodule // ssl_host

// ===== sim/ssl_link_tb.sv
// self-checking bench for the serial slave link with a host model
// assumes bit time is CLK_HZ over baud, shortened clocks for ms and 100 ms
`timescale 1ns/10ps
module ssl_link_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] comm_type = 2'h0;
  logic [2:0] baud_code = 3'h5;
  logic [1:0] fmt_code = 2'h0;
  logic [7:0] station_addr = 8'h01;
  logic [4:0] resp_delay_ms = 5'h02;
  logic [9:0] timeout_100ms = 10'h000;
  logic proto_std = 1'b1;
  logic cur_res_coarse = 1'b0;
  logic ans_valid = 1'b0;
  logic [15:0] ans_data = 16'hbeef;
  logic [15:0] cur_raw_10ma = 16'h04d2;
  logic fault_clear = 1'b0;
  logic [31:0] bit_cyc = 32'd40;
  logic oe_q = 1'b0;
  wire rx_pin, tx_pin, tx_oe, req_valid_q, req_bcast_q, link_timeout_fault_q;
  wire [7:0] req_func_q;
  wire [15:0] req_reg_q, req_val_q;
  int err_count = 0, samples_checked = 0, cyc = 0, nreq = 0, t_req = 0, t_oe = 0;
  int lag = 3, ans_cnt = 0;
  always #2.5 clk_sys = ~clk_sys;
  ssl_link #(.CLK_HZ(384000), .CYC_PER_MS(20), .CYC_PER_100MS(200)) u_ssl_link (
    .clk_sys, .reset_n, .comm_type, .baud_code, .fmt_code, .station_addr, .resp_delay_ms,
    .timeout_100ms, .proto_std, .cur_res_coarse, .rx_pin, .tx_pin, .tx_oe, .req_valid_q,
    .req_bcast_q, .req_func_q, .req_reg_q, .req_val_q, .ans_valid, .ans_data, .cur_raw_10ma,
    .link_timeout_fault_q, .fault_clear);
  ssl_host u_ssl_host (.clk_sys, .rx_pin, .tx_pin, .tx_oe, .bit_cyc, .fmt(fmt_code));
  // drive-logic stand-in answering lag cycles after each request; timestamps
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    oe_q <= tx_oe;
    ans_valid <= (ans_cnt == 1);
    ans_cnt <= req_valid_q ? lag : (ans_cnt != 0 ? ans_cnt - 1 : 0);
    if (req_valid_q) nreq <= nreq + 1;
    if (req_valid_q) t_req <= cyc;
    if (tx_oe && !oe_q) t_oe <= cyc;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one read frame; n reply bytes expected (0 for none), q whether it is taken
  task automatic txn(input logic [7:0] a, input logic [15:0] r, input logic bad,
                     input logic [15:0] d, input int n, input int q);
    logic [7:0] e[$];
    logic [15:0] c;
    int k, n0, lo;
    n0 = nreq;
    lo = (resp_delay_ms * 20 > lag) ? resp_delay_ms * 20 : lag;
    u_ssl_host.rxq.delete();
    u_ssl_host.send(a, r, bad);
    for (k = 0; k < bit_cyc * 150 + 1000 && (n == 0 || u_ssl_host.rxq.size() < n); k++)
      @(posedge clk_sys);
    e = '{a, 8'h03, 8'h02, d[15:8], d[7:0]};
    if (!proto_std) e.push_back(8'h00);
    c = u_ssl_host.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    check(nreq - n0, q);
    if (q) check(req_bcast_q, a == 8'h00);
    for (k = 0; k < n; k++) check(u_ssl_host.rxq[k], e[k]);
    if (n) check(t_oe - t_req >= lo - 2 && t_oe - t_req <= lo + 12, 1);
    if (q) check({req_func_q, req_reg_q}, {8'h03, r});
    if (q) check(req_val_q, 16'h0001);
    // count after the tail so that a surplus reply byte is caught too
    repeat (bit_cyc * 24) @(posedge clk_sys);
    check(u_ssl_host.rxq.size(), n);
  endtask
  // hang guard, well above the expected run length
  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    txn(8'h01, 16'h0005, 1'b0, 16'hbeef, 7, 1);
    // rates, formats, framing, resolution, delay against slow processing
    for (int i = 0; i < 4; i++) begin
      baud_code <= 3'(4 + i);
      fmt_code <= 2'(i);
      proto_std <= i[0];
      cur_res_coarse <= i[1];
      resp_delay_ms <= 5'(i == 3 ? 20 : i * 6);
      bit_cyc <= 32'd1280 >> (4 + i);
      lag = (i == 3) ? 600 : 3;
      @(posedge clk_sys);
      txn(8'h01, 16'h0000, 1'b0, i[1] ? 16'h007b : 16'h04d2, i[0] ? 7 : 8, 1);
    end
    lag = 3;
    txn(8'h02, 16'h0005, 1'b0, 16'h0, 0, 0);
    txn(8'h01, 16'h0005, 1'b1, 16'h0, 0, 0);
    comm_type <= 2'h1;
    txn(8'h01, 16'h0005, 1'b0, 16'h0, 0, 0);
    comm_type <= 2'h0;
    station_addr <= 8'h00;
    txn(8'h01, 16'h0005, 1'b0, 16'h0, 0, 0);
    timeout_100ms <= 10'h003;
    txn(8'h00, 16'h0005, 1'b0, 16'h0, 0, 1);
    check(link_timeout_fault_q, 1'b1);
    timeout_100ms <= 10'h000;
    fault_clear <= 1'b1;
    @(posedge clk_sys);
    fault_clear <= 1'b0;
    repeat (800) @(posedge clk_sys);
    check(link_timeout_fault_q, 1'b0);
    complete_run();
  end
endmodule // ssl_link_tb
bind ssl_link ssl_link_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.clk_sys, .reset_n,
  .comm_type, .station_addr, .resp_delay_ms, .timeout_100ms, .tx_pin, .tx_oe, .req_valid_q,
  .req_bcast_q, .ans_valid, .link_timeout_fault_q, .fault_clear);
